// ==== uil_defines.svh ====
`ifndef UIL_DEFINES_SVH
`define UIL_DEFINES_SVH

// Register byte addresses on the APB
`define UIL_ADDR_IER      32'hE0010004
`define UIL_ADDR_IIR      32'hE0010008

// Enable register field positions
`define UIL_IER_RDA       0
`define UIL_IER_TX_HOLDING_EMPTY      1
`define UIL_IER_RLS       2
`define UIL_IER_MSR       3

// Reset values
`define UIL_IER_RST       4'h0
`define UIL_IIR_RST       8'h01

// Receive trigger levels in characters, indexed by trigger select
`define UIL_TRIG_L0       5'h01
`define UIL_TRIG_L1       5'h04
`define UIL_TRIG_L2       5'h08
`define UIL_TRIG_L3       5'h0E

// Character time-out terms, counted in receive sample ticks
`define UIL_WL_BASE       4'h5
`define UIL_CTI_MUL       10'h007
`define UIL_CTI_SUB       10'h002
`define UIL_CTI_ADD       10'h001

`endif

// ==== uil_pkg.sv ====
package uil_pkg;

    // Identification codes, bits 3:1 of the identification register
    typedef enum logic [2:0] {
        IID_RLS   = 3'b011,
        IID_RDA   = 3'b010,
        IID_CTI   = 3'b110,
        IID_TX_HOLDING_EMPTY  = 3'b001,
        IID_MODEM = 3'b000
    } uil_iid_t;

endpackage

// ==== uil_timeout.sv ====
`timescale 1ns/1ps
`include "uil_defines.svh"

module uil_timeout (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Receive FIFO side
    input  wire logic       sample_tick,
    input  wire logic       activity,
    input  wire logic       armed,
    input  wire logic [9:0] limit,
    // Time-out flag
    output logic            expired
);

    logic [9:0] count_q;
    logic [9:0] count_d;
    logic       flag_q;
    logic       flag_d;
    logic       hit;

    // Idle counter restarts on any FIFO activity or an empty FIFO
    always_comb begin
        hit     = armed & sample_tick & ~flag_q & ((count_q + 10'h001) >= limit);
        count_d = count_q;
        if (activity || !armed) begin
            count_d = 10'h000;
        end else if (sample_tick && !flag_q) begin
            count_d = count_q + 10'h001;
        end
        // Expiry in the same cycle as activity still sets the flag
        flag_d = hit | (flag_q & ~activity & armed); // see RQ16
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= 10'h000;
            flag_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            flag_q  <= flag_d;
        end
    end

    assign expired = flag_q;

endmodule

// ==== uil_top.sv ====
`timescale 1ns/1ps
`include "uil_defines.svh"

// Summary of operation
// RQ1 - Enable bit 0 gates both data-available and character time-out interrupts.
// RQ2 - Enable bit 1 gates transmit-empty; empty status stays in line status bit 5.
// RQ3 - Enable bit 2 gates line status interrupt; errors show in line status 4:1.
// RQ4 - Enable bit 3 gates modem interrupt; change flags show in modem status 3:0.
// RQ5 - Software writes no ones to reserved bits; their read value is undefined.
// RQ6 - Identification bit 0 is low while any enabled interrupt pends; resets high.
// RQ7 - Bits 3:1 give the top pending source: 011, 010, 110, 001, 000.
// RQ8 - Identification bits 7:6 both mirror the FIFO enable bit; reset to zero.
// RQ9 - Interrupt state freezes during identification reads; new events show next read.
// RQ10 - Service software reads identification to clear the interrupt before returning.
// RQ11 - Line status interrupt is highest; set on overrun, parity, framing or break.
// RQ12 - Line status interrupt clears when software reads the line status register.
// RQ13 - Data-available and time-out share second priority, above transmit empty.
// RQ14 - Data-available asserts at the FIFO trigger level, drops below it.
// RQ15 - Time-out asserts with data in FIFO and no activity for the delay.
// RQ16 - Any receive FIFO read or write clears the character time-out interrupt.
// RQ17 - Transmit-empty clears on holding write or identification read while topmost.
// RQ18 - Modem interrupt sets on input changes or ring rise; status read clears.
// RQ19 - Time-out delay is ((word length*7-2)*8 + (trigger-count)*8+1) sample ticks.
// RQ20 - Interrupt request output is high whenever any enabled source is pending.

module uil_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Configuration from the rest of the UART
    input  wire logic        fifo_enable,
    input  wire logic [1:0]  rx_trigger,
    input  wire logic [1:0]  word_len_sel,
    input  wire logic        divisor_access_bit,
    // Receive side status and strobes
    input  wire logic [4:0]  rx_fifo_level,
    input  wire logic        rx_fifo_read,
    input  wire logic        rx_fifo_write,
    input  wire logic        line_err_event,
    input  wire logic        lsr_read,
    input  wire logic        sample_tick,
    // Transmit side status and strobes
    input  wire logic        tx_holding_empty,
    input  wire logic        thr_write,
    // Modem side strobes
    input  wire logic        modem_change,
    input  wire logic        msr_read,
    // Interrupt request
    output logic             irq
);

    // Bus registers
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pready_q;
    logic        pready_d;
    logic        pslverr_q;
    logic        pslverr_d;
    logic [3:0]  ier_q;
    logic [3:0]  ier_d;

    // Source flags
    logic        rls_q;
    logic        rls_d;
    logic        tx_holding_empty_q;
    logic        tx_holding_empty_d;
    logic        tx_holding_empty_prev_q;
    logic        tx_holding_empty_prev_d;
    logic        modem_q;
    logic        modem_d;

    // Identification state
    logic [7:0]  iir_q;
    logic [7:0]  iir_d;
    logic        irq_q;
    logic        irq_d;

    // Decode and priority terms
    logic        acc_setup;
    logic        acc_done;
    logic        sel_ier;
    logic        sel_iir;
    logic        iir_busy;
    logic        iir_done;
    logic [4:0]  trig_level;
    logic        rda_level;
    logic        cti_flag;
    logic        cti_armed;
    logic        rx_activity;
    logic        p_rls;
    logic        p_rda;
    logic        p_cti;
    logic        p_tx_holding_empty;
    logic        p_modem;
    logic        any_pending;
    uil_pkg::uil_iid_t iid;

    // Time-out delay terms
    logic [3:0]  word_len;
    logic [4:0]  trig_gap;
    logic [9:0]  cti_base;
    logic [9:0]  cti_limit;

    // Address decode; the enable register hides behind the divisor latch
    // Freeze window spans setup and access, so the code latched in setup
    // is the one the completing edge acts on
    always_comb begin
        acc_setup = psel & ~penable;
        acc_done  = psel & penable & pready_q;
        sel_ier   = (paddr == `UIL_ADDR_IER) & ~divisor_access_bit;
        sel_iir   = (paddr == `UIL_ADDR_IIR);
        iir_busy  = psel & sel_iir & ~pwrite;
        iir_done  = acc_done & sel_iir & ~pwrite;
    end

    // Trigger level from the FIFO control select
    // Without FIFOs the select is ignored by the level source below
    always_comb begin
        if (rx_trigger == 2'b00) begin
            trig_level = `UIL_TRIG_L0;
        end else if (rx_trigger == 2'b01) begin
            trig_level = `UIL_TRIG_L1;
        end else if (rx_trigger == 2'b10) begin
            trig_level = `UIL_TRIG_L2;
        end else begin
            trig_level = `UIL_TRIG_L3;
        end
    end

    // Time-out delay; a FIFO above trigger adds no gap term
    // Worst case, eight-bit words, trigger 14 and one character, needs
    // 537 ticks, which still fits the ten-bit limit
    always_comb begin
        word_len  = {2'b00, word_len_sel} + `UIL_WL_BASE;
        trig_gap  = (trig_level > rx_fifo_level) ? (trig_level - rx_fifo_level) : 5'h00;
        cti_base  = ({6'h00, word_len} * `UIL_CTI_MUL - `UIL_CTI_SUB) << 3; // see RQ19
        cti_limit = cti_base + {2'b00, trig_gap, 3'b000} + `UIL_CTI_ADD; // see RQ19
    end

    // Receive FIFO activity restarts and clears the time-out
    // A FIFO drained to empty disarms the timer and restarts its count
    always_comb begin
        rx_activity = rx_fifo_read | rx_fifo_write; // see RQ16
        cti_armed   = fifo_enable & (rx_fifo_level != 5'h00); // see RQ15
    end

    // Idle timer for the character time-out
    uil_timeout u_timeout (
        .clk         (clk),
        .rst         (rst),
        .sample_tick (sample_tick),
        .activity    (rx_activity),
        .armed       (cti_armed),
        .limit       (cti_limit),
        .expired     (cti_flag)
    );

    // Level source; without FIFOs one character is the trigger
    // Follows the count directly, so only draining the FIFO clears it
    always_comb begin
        if (fifo_enable) begin
            rda_level = (rx_fifo_level >= trig_level); // see RQ14
        end else begin
            rda_level = (rx_fifo_level != 5'h00);
        end
    end

    // Sticky sources; a set in the clearing cycle wins
    // so an event racing its own clear is never lost
    always_comb begin
        tx_holding_empty_prev_d = tx_holding_empty;
        rls_d       = line_err_event | (rls_q & ~lsr_read); // see RQ11 see RQ12
        modem_d     = modem_change | (modem_q & ~msr_read); // see RQ18
        tx_holding_empty_d      = tx_holding_empty_q;
        // Clear on holding write, or on a read that reported it
        if (thr_write || (iir_done && !iir_q[0] && iir_q[3:1] == uil_pkg::IID_TX_HOLDING_EMPTY)) begin
            tx_holding_empty_d = 1'b0; // see RQ17
        end
        // Empty edge from the transmitter, which shows it in line status too
        if (tx_holding_empty && !tx_holding_empty_prev_q) begin
            tx_holding_empty_d = 1'b1; // see RQ2
        end
    end

    // Gate each source by its enable bit
    // Enables only mask reporting; the flags underneath keep their state
    always_comb begin
        p_rls       = rls_q & ier_q[`UIL_IER_RLS]; // see RQ3
        p_rda       = rda_level & ier_q[`UIL_IER_RDA]; // see RQ1
        p_cti       = cti_flag & ier_q[`UIL_IER_RDA]; // see RQ1
        p_tx_holding_empty      = tx_holding_empty_q & ier_q[`UIL_IER_TX_HOLDING_EMPTY]; // see RQ2
        p_modem     = modem_q & ier_q[`UIL_IER_MSR]; // see RQ4
        any_pending = p_rls | p_rda | p_cti | p_tx_holding_empty | p_modem;
    end

    // Fixed priority encoder
    // Time-out sits below data-available on the shared level; both clear
    // through the FIFO, so the order only decides what is reported
    always_comb begin
        if (p_rls) begin
            iid = uil_pkg::IID_RLS; // see RQ11
        end else if (p_rda) begin
            iid = uil_pkg::IID_RDA; // see RQ13
        end else if (p_cti) begin
            iid = uil_pkg::IID_CTI; // see RQ13
        end else if (p_tx_holding_empty) begin
            iid = uil_pkg::IID_TX_HOLDING_EMPTY;
        end else begin
            iid = uil_pkg::IID_MODEM;
        end
    end

    // Snapshot held through a read so the reported code cannot change
    // under the processor; the sticky flags keep collecting meanwhile
    always_comb begin
        if (iir_busy) begin
            iir_d = iir_q; // see RQ9
            irq_d = irq_q; // see RQ9
        end else begin
            iir_d = {fifo_enable, fifo_enable, 2'b00, iid, ~any_pending}; // see RQ6 see RQ7 see RQ8
            irq_d = any_pending; // see RQ20
        end
    end

    // APB slave: data set up in the setup cycle, one access cycle
    always_comb begin
        pready_d  = acc_setup;
        prdata_d  = 32'h00000000;
        pslverr_d = 1'b0;
        ier_d     = ier_q;
        if (acc_setup) begin
            if (sel_ier) begin
                // Reserved upper bits read as zero
                prdata_d = {28'h0000000, ier_q};
            end else if (sel_iir) begin
                // Writes here belong to FIFO control and are ignored
                prdata_d = pwrite ? 32'h00000000 : {24'h000000, iir_q};
            end else begin
                pslverr_d = 1'b1;
            end
        end
        // Write lands at the completing edge only, never in setup
        // Only the four defined enable bits are stored
        if (acc_done && pwrite && sel_ier) begin
            ier_d = pwdata[3:0]; // see RQ1 see RQ2 see RQ3 see RQ4
        end
    end

    // Bus side registers; ready and read data stand for one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            ier_q     <= `UIL_IER_RST;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            ier_q     <= ier_d;
        end
    end

    // Sticky source flags and the empty-edge detector
    // Detector resets low, so a holding register already empty at
    // start-up raises one transmit-empty request after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            rls_q       <= 1'b0;
            tx_holding_empty_q      <= 1'b0;
            tx_holding_empty_prev_q <= 1'b0;
            modem_q     <= 1'b0;
        end else begin
            rls_q       <= rls_d;
            tx_holding_empty_q      <= tx_holding_empty_d;
            tx_holding_empty_prev_q <= tx_holding_empty_prev_d;
            modem_q     <= modem_d;
        end
    end

    // Identification snapshot and request line
    always_ff @(posedge clk) begin
        if (rst) begin
            iir_q <= `UIL_IIR_RST;
            irq_q <= 1'b0;
        end else begin
            iir_q <= iir_d;
            irq_q <= irq_d;
        end
    end

    // Outputs straight from flops
    // irq and the pending bit share one snapshot, so they never disagree
    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign irq     = irq_q;

endmodule

// ==== uil_irq_host.sv ====
`timescale 1ns/1ps

module uil_irq_host (
    // Clock, reset and request line
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       irq,
    // Requests taken so far
    output logic      [7:0] taken_q
);
    logic       irq_q;
    logic [7:0] taken_d;

    // Level request: only a fresh rise is a new interrupt
    always_comb taken_d = taken_q + {7'h00, irq & ~irq_q};
    always_ff @(posedge clk) begin
        irq_q   <= rst ? 1'b0 : irq;
        taken_q <= rst ? 8'h00 : taken_d;
    end
endmodule

// ==== uil_monitor.sv ====
`timescale 1ns/1ps
`include "uil_defines.svh"

module uil_monitor (
    // Clock, reset and APB
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Strobes and request
    input wire logic        line_err_event,
    input wire logic        lsr_read,
    input wire logic        tx_holding_empty,
    input wire logic        thr_write,
    input wire logic        modem_change,
    input wire logic        msr_read,
    input wire logic        irq
);
    logic [3:0] ier_q;
    logic [3:0] ier_d;
    logic       rd_id;
    logic       wr_en;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Shadow of the enable register, taken at completed writes
    assign rd_id = psel && !pwrite && paddr == `UIL_ADDR_IIR;
    assign wr_en = psel && penable && pready && pwrite && paddr == `UIL_ADDR_IER;
    always_comb ier_d = (wr_en && !pslverr) ? pwdata[3:0] : ier_q;
    always_ff @(posedge clk) ier_q <= rst ? 4'h0 : ier_d;

    irq_pend_a: assert property (rd_id && pready |-> prdata[0] == !irq)
        else $error("irq and pending flag differ");
    id_mirror_a: assert property (rd_id && pready |-> prdata[7] == prdata[6])
        else $error("fifo enable bits differ");
    id_freeze_a: assert property (rd_id && penable |-> $stable(irq))
        else $error("irq moved during read");
    rls_set_a: assert property (
        line_err_event && ier_q[2] && !psel ##1 !psel |=> irq)
        else $error("line error not raised");
    src_gate_a: assert property ((ier_q == 4'h0 && !psel) [*3] |-> !irq)
        else $error("masked source raised irq");
    lsr_clear_a: assert property (
        lsr_read && ier_q == 4'h4 && !line_err_event && !psel ##1 !psel |=> !irq)
        else $error("line status read kept irq");
    thr_clear_a: assert property (
        thr_write && ier_q == 4'h2 && !$rose(tx_holding_empty) && !psel ##1 !psel |=> !irq)
        else $error("holding write kept irq");
    msr_clear_a: assert property (
        msr_read && ier_q == 4'h8 && !modem_change && !psel ##1 !psel |=> !irq)
        else $error("modem read kept irq");
endmodule

bind uil_top uil_monitor uil_monitor_inst (.*);

// ==== uil_top_tb_top.sv ====
`timescale 1ns/1ps
`include "uil_defines.svh"

module uil_top_tb_top;
    localparam logic [31:0] IER = `UIL_ADDR_IER;
    localparam logic [31:0] IIR = `UIL_ADDR_IIR;
    localparam logic [32:0] BAD = 33'h1_0000_0000;
    localparam logic [6:0]  LE = 7'h40, LR = 7'h20, TW = 7'h10, MC = 7'h08, MR = 7'h04;
    localparam logic [6:0]  FR = 7'h02, FW = 7'h01;
    // Five-bit words, trigger 14, one character held
    localparam int          CTI_N = (5 * 7 - 2) * 8 + (14 - 1) * 8 + 1;
    // Eight-bit words, same trigger and fill
    localparam int          CTI_W8 = (8 * 7 - 2) * 8 + (14 - 1) * 8 + 1;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [31:0] paddr, pwdata, prdata;
    logic        fifo_enable, divisor_access_bit, sample_tick, tx_holding_empty;
    logic [1:0]  rx_trigger, word_len_sel;
    logic [4:0]  rx_fifo_level;
    logic [6:0]  ev_q;
    logic [7:0]  taken_q;
    logic [32:0] r_q;
    logic [4:0]  trig [4] = '{`UIL_TRIG_L0, `UIL_TRIG_L1, `UIL_TRIG_L2, `UIL_TRIG_L3};
    wire         line_err_event, lsr_read, thr_write, modem_change, msr_read;
    wire         rx_fifo_read, rx_fifo_write;
    int          mismatches, tests_run, cycles;

    // Strobes share one vector so any mix pulses together
    assign {line_err_event, lsr_read, thr_write, modem_change, msr_read,
            rx_fifo_read, rx_fifo_write} = ev_q;

    uil_top uil_top_inst (.*);
    uil_irq_host uil_irq_host_inst (.clk(clk), .rst(rst), .irq(irq), .taken_q(taken_q));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic summarize();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Setup then access until pready; one idle edge after
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic ev, output logic [32:0] r);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        ev_q    <= {ev, 6'h00};
        @(posedge clk);
        penable <= 1'b1;
        ev_q    <= 7'h00;
        // Wait as long as the slave needs; only the hang guard ends it
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = {pslverr, prdata};
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [31:0] a, input logic [32:0] x);
        apb(1'b0, a, 32'h0, 1'b0, r_q);
        chk(r_q, x);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0, r_q);
    endtask

    task automatic rid(input logic [2:0] c, input logic p);
        rd(IIR, {25'h0, fifo_enable, fifo_enable, 2'b00, c, ~p});
    endtask

    task automatic pulse(input logic [6:0] m);
        ev_q <= m;
        @(posedge clk);
        ev_q <= 7'h00;
        repeat (3) @(posedge clk);
    endtask

    task automatic t_reset();
        rd(IER, 33'h0);
        rid(3'b000, 1'b0);
        fifo_enable <= 1'b1;
        pulse(7'h00);
        rid(3'b000, 1'b0);
        wr(IER, 32'hF);
        rd(IER, 33'hF);
        rd(32'hE001_0020, BAD);
        divisor_access_bit <= 1'b1;
        rd(IER, BAD);
        divisor_access_bit <= 1'b0;
    endtask

    task automatic t_prio();
        pulse(MC);
        rid(uil_pkg::IID_MODEM, 1'b1);
        tx_holding_empty <= 1'b1;
        pulse(7'h00);
        rid(uil_pkg::IID_TX_HOLDING_EMPTY, 1'b1);
        rx_fifo_level <= 5'h01;
        pulse(LE);
        rid(uil_pkg::IID_RLS, 1'b1);
        pulse(LR);
        rid(uil_pkg::IID_RDA, 1'b1);
        // The first transmit-empty read cleared it; a fresh empty edge re-arms it
        rx_fifo_level    <= 5'h00;
        tx_holding_empty <= 1'b0;
        pulse(7'h00);
        tx_holding_empty <= 1'b1;
        pulse(7'h00);
        rid(uil_pkg::IID_TX_HOLDING_EMPTY, 1'b1);
        rid(uil_pkg::IID_MODEM, 1'b1);
        pulse(MR);
        rid(uil_pkg::IID_MODEM, 1'b0);
        chk({25'h0, taken_q}, 33'h1);
    endtask

    task automatic t_gate();
        wr(IER, 32'h0);
        tx_holding_empty <= 1'b0;
        pulse(MC | LE);
        tx_holding_empty <= 1'b1;
        rx_fifo_level <= 5'h01;
        pulse(7'h00);
        rid(uil_pkg::IID_MODEM, 1'b0);
        wr(IER, 32'h2);
        pulse(7'h00);
        chk({32'h0, irq}, 33'h1);
        pulse(TW);
        chk({32'h0, irq}, 33'h0);
        pulse(LR);
        wr(IER, 32'h4);
        apb(1'b0, IIR, 32'h0, 1'b1, r_q);
        chk(r_q, 33'hC1);
        pulse(7'h00);
        rid(uil_pkg::IID_RLS, 1'b1);
        pulse(LR);
        wr(IER, 32'h8);
        rid(uil_pkg::IID_MODEM, 1'b1);
        pulse(MR);
        wr(IER, 32'h1);
        rid(uil_pkg::IID_RDA, 1'b1);
    endtask

    task automatic t_trig();
        for (int i = 0; i < 4; i++) begin
            rx_trigger    <= i[1:0];
            rx_fifo_level <= trig[i] - 5'h01;
            pulse(7'h00);
            rid(uil_pkg::IID_MODEM, 1'b0);
            rx_fifo_level <= trig[i];
            pulse(7'h00);
            rid(uil_pkg::IID_RDA, 1'b1);
        end
        // Without FIFOs a single character is enough
        fifo_enable   <= 1'b0;
        rx_fifo_level <= 5'h01;
        pulse(7'h00);
        rid(uil_pkg::IID_RDA, 1'b1);
        fifo_enable   <= 1'b1;
    endtask

    task automatic t_cti();
        rx_fifo_level <= 5'h01;
        sample_tick   <= 1'b1;
        repeat (CTI_N - 8) @(posedge clk);
        chk({32'h0, irq}, 33'h0);
        repeat (16) @(posedge clk);
        chk({32'h0, irq}, 33'h1);
        rid(uil_pkg::IID_CTI, 1'b1);
        pulse(FR);
        chk({32'h0, irq}, 33'h0);
        repeat (CTI_N - 20) @(posedge clk);
        pulse(FW);
        repeat (40) @(posedge clk);
        chk({32'h0, irq}, 33'h0);
        // Eight-bit words stretch the delay; the write restarts the count
        word_len_sel <= 2'b11;
        pulse(FW);
        repeat (CTI_W8 - 12) @(posedge clk);
        chk({32'h0, irq}, 33'h0);
        repeat (16) @(posedge clk);
        chk({32'h0, irq}, 33'h1);
        sample_tick <= 1'b0;
    endtask

    initial begin
        rst = 1'b1;
        ev_q = 7'h00;
        {psel, penable, pwrite, paddr, pwdata, fifo_enable, divisor_access_bit} = '0;
        {sample_tick, tx_holding_empty, rx_trigger, word_len_sel, rx_fifo_level} = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_prio();
        t_gate();
        t_trig();
        t_cti();
        summarize();
    end
endmodule
